// [hdl/cs_cfg.svh]
`ifndef CS_CFG_SVH
`define CS_CFG_SVH

// Command codes on the serial link
`define CS_CMD_MODE    8'h12
`define CS_CMD_STATUS  8'h13
`define CS_CMD_CURR    8'h14
`define CS_CMD_VOLT    8'h15

// Bus addresses and the alert reply byte
`define CS_DEV_ADDR    7'h09
`define CS_ARA_ADDR    7'h0C
`define CS_ARA_REPLY   8'h13

// Code field positions in the set-point words
`define CS_CUR_LSB     7
`define CS_CUR_MSB     12
`define CS_VOLT_LSB    4
`define CS_VOLT_MSB    14

// Clamp and overrange limits
`define CS_CUR_MAX_MA  16'h1F80
`define CS_VOLT_MIN_MV 16'h0400
`define CS_VOLT_MAX_MV 16'h4B00
`define CS_CUR_OR_LIM  16'h1F80
`define CS_VOLT_OR_LIM 16'h4B00

// Mode word bits and reset value
`define CS_MODE_LOWIN_MASK 6
`define CS_MODE_PACK_MASK  5
`define CS_MODE_ADPT_MASK  4
`define CS_MODE_POR        3
`define CS_MODE_RST        16'h0000

// Safety timer: prescaled tick, then tick counter
`define CS_CLK_HZ        125000000
`define CS_TICK_MS       1
`define CS_TIMEOUT_S     175
`define CS_TICK_CYC      ((`CS_CLK_HZ / 1000) * `CS_TICK_MS)
`define CS_TIMEOUT_TICKS ((`CS_TIMEOUT_S * 1000) / `CS_TICK_MS)
`define CS_PRE_W         17
`define CS_TMR_W         18

`endif

// [hdl/cs_pkg.sv]
package cs_pkg;

  // Link byte phases, one-hot
  typedef enum logic [6:0] {
    LK_ADDR = 7'h01,
    LK_CMD  = 7'h02,
    LK_WLO  = 7'h04,
    LK_WHI  = 7'h08,
    LK_RD   = 7'h10,
    LK_ARA  = 7'h20,
    LK_IDLE = 7'h40
  } cs_link_e;

  // Pin-level status inputs
  typedef struct packed {
    logic       adapter;
    logic       pack;
    logic       low_in;
    logic       dropout;
    logic [3:0] therm;
  } cs_pins_s;

  // Link state cleared at every start or stop
  typedef struct packed {
    cs_link_e   st;
    logic [3:0] bitc;
    logic [7:0] shf;
    logic [7:0] dlo;
    logic       ack;
    logic       hi;
  } cs_link_s;

  // Link state that survives a repeated start
  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  wcmd;
    logic [15:0] wdata;
    logic        wr_tgl;
    logic        ara_tgl;
  } cs_xfer_s;

  // Open-drain data pin drive
  typedef struct packed {
    logic o;
    logic oe_n;
  } cs_drv_s;

  // System clock state
  typedef struct packed {
    logic [15:0] cur;
    logic [15:0] volt;
    logic [15:0] mode;
    logic [15:0] snap;
    logic [15:0] cur_ma;
    logic [15:0] volt_mv;
    logic [16:0] pre;
    logic [17:0] tmr;
    logic [2:0]  flg_l;
    logic        drop_l;
    logic        sda_l;
    logic        frm_rst;
    logic        wr_l;
    logic        ara_l;
    logic        pend;
    logic        hot;
    logic        lock;
    logic        seen_v;
    logic        seen_i;
    logic        chg_en;
    logic        int_n;
  } cs_sys_s;

endpackage

// [hdl/cs_sync.sv]
`timescale 1ns/100ps
module cs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // Two stages; only the second one is read outside
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// [hdl/cs_decode.sv]
`timescale 1ns/100ps
`include "cs_cfg.svh"
module cs_decode (
  input  wire logic [15:0] cur_word,
  input  wire logic [15:0] volt_word,
  output logic      [15:0] cur_ma,
  output logic      [15:0] volt_mv
);

  logic [15:0] ma_raw;
  logic [15:0] mv_raw;

  // Weighted code fields; bits outside them never reach the sum
  always_comb begin
    ma_raw = {3'h0, cur_word[`CS_CUR_MSB:`CS_CUR_LSB], 7'h00};
    mv_raw = {1'b0, volt_word[`CS_VOLT_MSB:`CS_VOLT_LSB], 4'h0};
    // Six bits top out at the limit; the clamp guards field edits
    cur_ma = (ma_raw > `CS_CUR_MAX_MA) ? `CS_CUR_MAX_MA : ma_raw;
    if (mv_raw < `CS_VOLT_MIN_MV) begin
      volt_mv = `CS_VOLT_MIN_MV;
    end else if (mv_raw > `CS_VOLT_MAX_MV) begin
      volt_mv = `CS_VOLT_MAX_MV;
    end else begin
      volt_mv = mv_raw;
    end
  end

endmodule

// [hdl/cs_top.sv]
`timescale 1ns/100ps
`include "cs_cfg.svh"
// Notes on behaviour
// - Current word bits 0-6, 13-15 ignored
// - Current bits 7-12 weigh 128mA upward
// - Current target never above 8064mA
// - Voltage word bits 0-3, 15 ignored
// - Voltage bits 4-14 weigh 16mV upward
// - Voltage target never below 1024mV
// - Voltage target never above 19200mV
// - Stop charging after 175s without set-point
// - Each set-point command restarts safety timer
// - Dropout entry or exit requests interrupt
// - Mode bits 6,5,4 mask flag interrupts
// - Alert response read clears pending interrupt
// - Alert reply arbitrates bitwise, lowest wins
// - Alert reply byte is 0x13
// - Four thermistor comparator flags in status
// - Status bits 13-15 change pulls interrupt
// - Current word above 0x1F80 flags overrange
// - Lockout set by expiry, cleared three ways
module cs_top #(
  parameter int TICK_CYC      = `CS_TICK_CYC,
  parameter int TIMEOUT_TICKS = `CS_TIMEOUT_TICKS
) (
  input  wire logic            clk_sys,
  input  wire logic            nrst,
  input  wire logic            scl_clk,
  input  wire logic            sda_in,
  output logic                 sda_out,
  output logic                 sda_oe_n,
  input  wire cs_pkg::cs_pins_s pins_in,
  output logic          [15:0] cur_ma,
  output logic          [15:0] volt_mv,
  output logic                 charge_en,
  output logic                 int_n
);

  localparam logic [`CS_PRE_W-1:0] PRE_LAST =
    `CS_PRE_W'(TICK_CYC - 1);
  localparam logic [`CS_TMR_W-1:0] TMR_LAST =
    `CS_TMR_W'(TIMEOUT_TICKS - 1);

  cs_pkg::cs_sys_s  s_q;
  cs_pkg::cs_sys_s  s_d;
  cs_pkg::cs_link_s l_q;
  cs_pkg::cs_link_s l_d;
  cs_pkg::cs_xfer_s x_q;
  cs_pkg::cs_xfer_s x_d;
  cs_pkg::cs_drv_s  dv_q;
  cs_pkg::cs_drv_s  dv_d;
  cs_pkg::cs_pins_s pins_s;

  logic [9:0]  sy_sys;
  logic [1:0]  tg_s;
  logic        pend_l;
  logic [15:0] dec_ma;
  logic [15:0] dec_mv;
  logic [15:0] stat;
  logic [2:0]  flg_chg;
  logic [2:0]  flg_irq;
  logic [7:0]  byte_c;
  logic        scl_s;
  logic        sda_s;
  logic        start_c;
  logic        stop_c;
  logic        wr_ev;
  logic        wr_v;
  logic        wr_i;
  logic        wr_m;
  logic        por_wr;
  logic        ara_ev;
  logic        tick;
  logic        expire;
  logic        drop_chg;
  logic        lrst_n;
  logic        tx;

  // Pins and link lines into the system domain
  cs_sync #(
    .W (10)
  ) u_pin_sync (
    .clk  (clk_sys),
    .nrst (nrst),
    .d    ({scl_clk, sda_in, pins_in}),
    .q    (sy_sys)
  );

  // Word events arrive as toggles; data already stands still
  cs_sync #(
    .W (2)
  ) u_tgl_sync (
    .clk  (clk_sys),
    .nrst (nrst),
    .d    ({x_q.wr_tgl, x_q.ara_tgl}),
    .q    (tg_s)
  );

  // Pending level into the link domain
  cs_sync #(
    .W (1)
  ) u_pend_sync (
    .clk  (scl_clk),
    .nrst (nrst),
    .d    (s_q.pend),
    .q    (pend_l)
  );

  // Set-point decode with clamping
  cs_decode u_dec (
    .cur_word  (s_q.cur),
    .volt_word (s_q.volt),
    .cur_ma    (dec_ma),
    .volt_mv   (dec_mv)
  );

  // Synchronised views and frame edges
  assign scl_s   = sy_sys[9];
  assign sda_s   = sy_sys[8];
  assign pins_s  = cs_pkg::cs_pins_s'(sy_sys[7:0]);
  assign start_c = s_q.sda_l & ~sda_s & scl_s;
  assign stop_c  = ~s_q.sda_l & sda_s & scl_s;

  // Decoded word writes from the link
  assign wr_ev  = tg_s[1] ^ s_q.wr_l;
  assign ara_ev = tg_s[0] ^ s_q.ara_l;
  assign wr_v   = wr_ev & (x_q.wcmd == `CS_CMD_VOLT);
  assign wr_i   = wr_ev & (x_q.wcmd == `CS_CMD_CURR);
  assign wr_m   = wr_ev & (x_q.wcmd == `CS_CMD_MODE);
  assign por_wr = wr_m & x_q.wdata[`CS_MODE_POR];

  // Safety timer terminal count
  assign tick   = (s_q.pre == PRE_LAST);
  assign expire = tick & (s_q.tmr == TMR_LAST) & ~s_q.lock;

  // Flag edges and their masks
  assign flg_chg  = {pins_s.low_in, pins_s.pack, pins_s.adapter}
                    ^ s_q.flg_l;
  assign flg_irq  = flg_chg & ~{s_q.mode[`CS_MODE_LOWIN_MASK],
                                s_q.mode[`CS_MODE_PACK_MASK],
                                s_q.mode[`CS_MODE_ADPT_MASK]};
  assign drop_chg = pins_s.dropout ^ s_q.drop_l;

  // Status word as the host reads it
  assign stat = {pins_s.adapter,
                 pins_s.pack,
                 pins_s.low_in,
                 s_q.lock,
                 pins_s.therm[0],
                 s_q.hot,
                 pins_s.therm[2],
                 pins_s.therm[3],
                 s_q.volt > `CS_VOLT_OR_LIM,
                 s_q.cur > `CS_CUR_OR_LIM,
                 1'b0,
                 1'b1,
                 2'b00,
                 1'b0,
                 ~s_q.chg_en};

  // System domain next state
  always_comb begin
    s_d         = s_q;
    s_d.sda_l   = sda_s;
    s_d.frm_rst = start_c | stop_c;
    s_d.wr_l    = tg_s[1];
    s_d.ara_l   = tg_s[0];
    s_d.flg_l   = {pins_s.low_in, pins_s.pack, pins_s.adapter};
    s_d.drop_l  = pins_s.dropout;
    // Snapshot at start; held still for the whole frame
    if (start_c) begin
      s_d.snap = stat;
    end
    if (wr_i) begin
      s_d.cur = x_q.wdata;
    end
    if (wr_v) begin
      s_d.volt = x_q.wdata;
    end
    if (wr_m) begin
      s_d.mode = x_q.wdata;
      s_d.mode[`CS_MODE_POR] = 1'b0;
    end
    // Prescaler feeds the tick counter, which holds at the end
    s_d.pre = tick ? '0 : s_q.pre + 1'b1;
    if (tick && (s_q.tmr != TMR_LAST)) begin
      s_d.tmr = s_q.tmr + 1'b1;
    end
    if (wr_v || wr_i) begin
      s_d.pre = '0;
      s_d.tmr = '0;
    end
    // Lockout: a pair of set-point writes, pack loss or POR clears
    if (wr_v) begin
      s_d.seen_v = 1'b1;
    end
    if (wr_i) begin
      s_d.seen_i = 1'b1;
    end
    if (!pins_s.pack || por_wr || (s_d.seen_v && s_d.seen_i)) begin
      s_d.lock   = 1'b0;
      s_d.seen_v = 1'b0;
      s_d.seen_i = 1'b0;
    end
    if (!pins_s.pack || por_wr) begin
      s_d.tmr = '0;
      s_d.pre = '0;
    end
    // Expiry wins over any clear in the same cycle
    if (expire) begin
      s_d.lock   = 1'b1;
      s_d.seen_v = 1'b0;
      s_d.seen_i = 1'b0;
    end
    // Hot flag latches until pack loss or POR
    if (pins_s.therm[1]) begin
      s_d.hot = 1'b1;
    end else if (!pins_s.pack || por_wr) begin
      s_d.hot = 1'b0;
    end
    // Pending request; a new event beats the alert clear
    if (ara_ev) begin
      s_d.pend = 1'b0;
    end
    if ((|flg_irq) || drop_chg) begin
      s_d.pend = 1'b1;
    end
    // Registered outputs
    s_d.cur_ma  = s_q.lock ? 16'h0000 : dec_ma;
    s_d.volt_mv = dec_mv;
    s_d.chg_en  = ~s_q.lock & pins_s.adapter & pins_s.pack;
    s_d.int_n   = ~s_q.pend;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q         <= '0;
      s_q.mode    <= `CS_MODE_RST;
      s_q.volt_mv <= `CS_VOLT_MIN_MV;
      s_q.sda_l   <= 1'b1;
      s_q.int_n   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Start or stop restarts the byte engine from the address
  assign lrst_n = nrst & ~s_q.frm_rst;
  assign byte_c = {l_q.shf[6:0], sda_in};
  assign tx     = (l_q.st == cs_pkg::LK_RD) | (l_q.st == cs_pkg::LK_ARA);

  // Link domain: sample on the rising clock edge
  always_comb begin
    l_d = l_q;
    x_d = x_q;
    if (l_q.bitc == 4'h8) begin
      l_d.bitc = 4'h0;
      l_d.ack  = 1'b0;
      // Master acknowledge slot after a byte that we sent
      if (!l_q.ack) begin
        if ((l_q.st == cs_pkg::LK_RD) && !sda_in && !l_q.hi) begin
          l_d.shf = s_q.snap[15:8];
          l_d.hi  = 1'b1;
        end else begin
          l_d.st = cs_pkg::LK_IDLE;
        end
      end
    end else begin
      l_d.bitc = l_q.bitc + 4'h1;
      l_d.shf  = tx ? {l_q.shf[6:0], 1'b1} : byte_c;
      unique case (l_q.st)
        cs_pkg::LK_ADDR: begin
          if (l_q.bitc == 4'h7) begin
            l_d.ack = 1'b1;
            if (byte_c[7:1] == `CS_DEV_ADDR && !byte_c[0]) begin
              l_d.st = cs_pkg::LK_CMD;
            end else if (byte_c[7:1] == `CS_DEV_ADDR &&
                         x_q.cmd == `CS_CMD_STATUS) begin
              l_d.st  = cs_pkg::LK_RD;
              l_d.shf = s_q.snap[7:0];
              l_d.hi  = 1'b0;
            end else if (byte_c[7:1] == `CS_ARA_ADDR &&
                         byte_c[0] && pend_l) begin
              l_d.st  = cs_pkg::LK_ARA;
              l_d.shf = `CS_ARA_REPLY;
            end else begin
              l_d.st  = cs_pkg::LK_IDLE;
              l_d.ack = 1'b0;
            end
          end
        end
        cs_pkg::LK_CMD: begin
          if (l_q.bitc == 4'h7) begin
            x_d.cmd = byte_c;
            l_d.st  = cs_pkg::LK_WLO;
            l_d.ack = 1'b1;
          end
        end
        cs_pkg::LK_WLO: begin
          if (l_q.bitc == 4'h7) begin
            l_d.dlo = byte_c;
            l_d.st  = cs_pkg::LK_WHI;
            l_d.ack = 1'b1;
          end
        end
        cs_pkg::LK_WHI: begin
          if (l_q.bitc == 4'h7) begin
            x_d.wcmd   = x_q.cmd;
            x_d.wdata  = {byte_c, l_q.dlo};
            x_d.wr_tgl = ~x_q.wr_tgl;
            l_d.st     = cs_pkg::LK_IDLE;
            l_d.ack    = 1'b1;
          end
        end
        cs_pkg::LK_RD: begin
        end
        cs_pkg::LK_ARA: begin
          // Released one seen low: a lower address wins the line
          if (l_q.shf[7] && !sda_in) begin
            l_d.st = cs_pkg::LK_IDLE;
          end else if (l_q.bitc == 4'h7) begin
            x_d.ara_tgl = ~x_q.ara_tgl;
          end
        end
        cs_pkg::LK_IDLE: begin
        end
        default: begin
          l_d.st = cs_pkg::LK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge scl_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      l_q    <= '0;
      l_q.st <= cs_pkg::LK_ADDR;
    end else begin
      l_q <= l_d;
    end
  end

  // Command and toggles must outlive a repeated start
  always_ff @(posedge scl_clk or negedge nrst) begin
    if (!nrst) begin
      x_q <= '0;
    end else begin
      x_q <= x_d;
    end
  end

  // Drive changes only while the clock is low
  always_comb begin
    dv_d.oe_n = ~(l_q.ack |
                  (tx & (l_q.bitc != 4'h8) & ~l_q.shf[7]));
    dv_d.o    = dv_d.oe_n;
  end

  always_ff @(negedge scl_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      dv_q <= 2'h3;
    end else begin
      dv_q <= dv_d;
    end
  end

  assign sda_out   = dv_q.o;
  assign sda_oe_n  = dv_q.oe_n;
  assign cur_ma    = s_q.cur_ma;
  assign volt_mv   = s_q.volt_mv;
  assign charge_en = s_q.chg_en;
  assign int_n     = s_q.int_n;

  // Current output follows the field of the word one cycle back
  cur_map_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !s_q.lock |=> s_q.cur_ma == {3'h0, $past(s_q.cur[12:7]), 7'h00})
    else $error("current set point does not follow the code");

  cur_max_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.cur_ma <= `CS_CUR_MAX_MA)
    else $error("current set point above its ceiling");

  volt_min_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.volt_mv >= `CS_VOLT_MIN_MV)
    else $error("voltage target below its floor");

  volt_max_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.volt_mv <= `CS_VOLT_MAX_MV)
    else $error("voltage target above its ceiling");

  volt_map_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ({1'b0, s_q.volt[14:4], 4'h0} >= `CS_VOLT_MIN_MV &&
     {1'b0, s_q.volt[14:4], 4'h0} <= `CS_VOLT_MAX_MV)
    |=> s_q.volt_mv == {1'b0, $past(s_q.volt[14:4]), 4'h0})
    else $error("voltage target does not follow the code");

  timer_stop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    expire |=> s_q.lock ##1 !s_q.chg_en)
    else $error("charging not stopped at timer expiry");

  timer_kick_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr_v || wr_i) |=> (s_q.tmr == '0) && (s_q.pre == '0))
    else $error("set-point command did not restart the timer");

  irq_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (|flg_irq) |=> s_q.pend ##1 !s_q.int_n)
    else $error("status flag change did not pull the interrupt");

  irq_mask_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!s_q.pend && (|flg_chg) && !(|flg_irq) && !drop_chg)
    |=> !s_q.pend)
    else $error("masked flag change raised an interrupt");

  drop_irq_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    drop_chg |=> s_q.pend)
    else $error("dropout change did not raise an interrupt");

  ara_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ara_ev && !(|flg_irq) && !drop_chg) |=> !s_q.pend ##1 s_q.int_n)
    else $error("alert response did not release the interrupt");

  lock_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (s_q.lock && !pins_s.pack && !expire) |=> !s_q.lock)
    else $error("pack removal did not clear the lockout");

  ara_reply_a: assert property (@(posedge scl_clk) disable iff (!lrst_n)
    (l_q.st == cs_pkg::LK_ADDR && l_d.st == cs_pkg::LK_ARA)
    |=> l_q.shf == `CS_ARA_REPLY)
    else $error("alert reply byte is wrong");

endmodule

// [sim/cs_host_model.sv]
`timescale 1ns/100ps
module cs_host_model (
  output logic      scl,
  output logic      sda_wire,
  input  wire logic dev_out,
  input  wire logic dev_oe_n
);
  logic drv_q;

  // Pulled-up line: low when either party pulls it
  assign sda_wire = drv_q & (dev_oe_n | dev_out);

  // Clock idles high between frames
  initial begin
    scl = 1'b1;
    drv_q = 1'b1;
  end

  // Data moves mid-low so it never mimics a start or stop
  task automatic clk_bit(input logic b, output logic got);
    scl = 1'b0;
    #12 drv_q = b;
    #12 scl = 1'b1;
    #12 got = sda_wire;
    #12; // Clock left high; the next fall belongs to the caller
  endtask

  // Byte out MSB first, then sample the acknowledge
  task automatic tx_byte(input logic [7:0] v, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(v[i], g);
    end
    clk_bit(1'b1, g);
    ack = ~g;
  endtask

  // A repeated start first frees the line with the clock low
  task automatic start(input logic rep);
    if (rep) begin
      scl = 1'b0;
      #12 drv_q = 1'b1;
      #12 scl = 1'b1;
    end
    #40 drv_q = 1'b0;
    #48;
  endtask

  task automatic stop;
    scl = 1'b0;
    #12 drv_q = 1'b0;
    #12 scl = 1'b1;
    #48 drv_q = 1'b1;
    #96;
  endtask

  // Set-point writes are what keep the charge alive
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] w,
                            output logic ok);
    logic a0, a1, a2, a3;
    start(1'b0);
    tx_byte(8'h12, a0);
    tx_byte(cmd, a1);
    tx_byte(w[7:0], a2);
    tx_byte(w[15:8], a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask

  // Receive-byte at the alert address; caller repeats while pending
  task automatic alert_read(output logic ok, output logic [7:0] v);
    logic g;
    start(1'b0);
    tx_byte(8'h19, ok);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, g);
      v[i] = g;
    end
    clk_bit(1'b1, g);
    stop();
  endtask

  // Read word: command, repeated start, low byte ACKed, high NACKed
  task automatic read_word(input logic [7:0] cmd, output logic ok,
                           output logic [15:0] v);
    logic a0, a1, a2, g;
    start(1'b0);
    tx_byte(8'h12, a0);
    tx_byte(cmd, a1);
    start(1'b1);
    tx_byte(8'h13, a2);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, g);
      v[i] = g;
    end
    clk_bit(1'b0, g);
    for (int i = 15; i >= 8; i--) begin
      clk_bit(1'b1, g);
      v[i] = g;
    end
    clk_bit(1'b1, g);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule

// [sim/test_charger_setpoint_regs_timer.sv]
`timescale 1ns/100ps
module test_charger_setpoint_regs_timer;
  localparam int K_CUR = 0, K_VOLT = 1, K_EN = 2, K_INT = 3, K_ARA = 4;
  localparam int K_ST = 6;
  logic             clk_sys, nrst, scl, sda_wire, sda_out, sda_oe_n;
  logic             charge_en, int_n, ack;
  cs_pkg::cs_pins_s pins;
  logic [15:0]      cur_ma, volt_mv, w, st_word;
  logic [7:0]       ara_byte;
  int               bad_count = 0, num_checks = 0, seed = 49, cycles = 0;
  int               kq[$];
  logic [15:0]      eq[$];
  logic [15:0]      cw[5] = '{16'hFFFF, 16'h007F, 16'h0080, 16'hE000,
                              16'h1F80};
  logic [15:0]      vw[6] = '{16'h0000, 16'hFFFF, 16'h03FF, 16'h4B0F,
                              16'h1230, 16'h4B10};
  event             obs_ev;

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  cs_top #(.TICK_CYC(16), .TIMEOUT_TICKS(200)) cs_top_inst (
    .clk_sys(clk_sys), .nrst(nrst), .scl_clk(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pins_in(pins),
    .cur_ma(cur_ma), .volt_mv(volt_mv), .charge_en(charge_en),
    .int_n(int_n));

  cs_host_model cs_host_model_inst (
    .scl(scl), .sda_wire(sda_wire), .dev_out(sda_out),
    .dev_oe_n(sda_oe_n));

  task automatic summarize;
    $display("checks=%0d bad=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic note(input int k, input logic [15:0] e);
    kq.push_back(k);
    eq.push_back(e);
  endtask

  // Let outputs settle, then hand the notes to the monitor
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1 -> obs_ev;
    #1;
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    cs_host_model_inst.write_word(cmd, d, ack);
    note(5, 16'h0001);
    settle(1); // Each frame's acknowledge checked before the next
  endtask

  task automatic ara(input logic exp_ack);
    cs_host_model_inst.alert_read(ack, ara_byte);
    note(5, {15'h0000, exp_ack});
    note(K_ARA, exp_ack ? 16'h0013 : 16'h00FF);
    note(K_INT, 16'h0001);
    settle(8);
  endtask

  task automatic set_pins(input logic [7:0] v);
    @(posedge clk_sys);
    pins <= v;
  endtask

  // Own clamp model, independent of the decoder
  function automatic logic [15:0] vexp(input logic [15:0] d);
    logic [15:0] m;
    m = d & 16'h7FF0;
    if (m < 16'h0400) m = 16'h0400;
    if (m > 16'h4B00) m = 16'h4B00;
    return m;
  endfunction

  // Monitor: oldest note against the output it names
  initial begin
    int k;
    logic [15:0] e;
    forever begin
      @(obs_ev);
      while (kq.size() > 0) begin
        k = kq.pop_front();
        e = eq.pop_front();
        case (k)
          K_CUR:   cmp16(cur_ma, e);
          K_VOLT:  cmp16(volt_mv, e);
          K_ARA:   cmp16({8'h00, ara_byte}, e);
          K_ST:    cmp16(st_word, e);
          K_EN:    cmp1(charge_en, e[0]);
          K_INT:   cmp1(int_n, e[0]);
          default: cmp1(ack, e[0]);
        endcase
      end
    end
  end

  // Hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    nrst = 1'b0;
    pins = 8'hC0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    note(K_INT, 16'h0000);
    note(K_EN, 16'h0001);
    settle(8);
    ara(1'b1);
    $display("test startup_alert done");
    for (int i = 0; i < 8; i++) begin
      w = (i < 5) ? cw[i] : 16'($random(seed));
      wr(8'h14, w);
      note(K_CUR, w & 16'h1F80);
      settle(8);
    end
    $display("test current done");
    for (int i = 0; i < 9; i++) begin
      w = (i < 6) ? vw[i] : 16'($random(seed));
      wr(8'h15, w);
      note(K_VOLT, vexp(w));
      settle(8);
    end
    $display("test voltage done");
    // Keep-alive just inside the window, then let it lapse
    repeat (2500) @(posedge clk_sys);
    wr(8'h14, 16'h0400);
    repeat (2500) @(posedge clk_sys);
    note(K_EN, 16'h0001);
    settle(8);
    repeat (3300) @(posedge clk_sys);
    note(K_EN, 16'h0000);
    note(K_CUR, 16'h0000);
    settle(8);
    wr(8'h15, 16'h3000);
    wr(8'h14, 16'h0400);
    note(K_EN, 16'h0001);
    note(K_CUR, 16'h0400);
    settle(8);
    $display("test timer done");
    // Overrange words and every comparator set, then read status back
    wr(8'h15, 16'h4B10);
    wr(8'h14, 16'hFFFF);
    set_pins(8'hCF);
    note(K_CUR, 16'h1F80);
    note(K_VOLT, 16'h4B00);
    cs_host_model_inst.read_word(8'h13, ack, st_word);
    note(5, 16'h0001);
    note(K_ST, 16'hCFD0);
    settle(8);
    $display("test status done");
    // Let the timer lapse; the pack removal below must clear the lockout
    repeat (3300) @(posedge clk_sys);
    note(K_EN, 16'h0000);
    settle(8);
    wr(8'h12, 16'h0070);
    set_pins(8'h20);
    note(K_INT, 16'h0001);
    settle(8);
    set_pins(8'hC0);
    note(K_INT, 16'h0001);
    note(K_EN, 16'h0001);
    settle(8);
    wr(8'h12, 16'h0000);
    set_pins(8'hE0);
    note(K_INT, 16'h0000);
    settle(8);
    ara(1'b1);
    wr(8'h12, 16'h0070);
    set_pins(8'hF0);
    note(K_INT, 16'h0000);
    settle(8);
    ara(1'b1);
    ara(1'b0);
    $display("test mask_alert done");
    summarize();
  end
endmodule
